// ### tb/serial_port_status_control_bench.sv
// self-checking bench for the serial port status / control bank
`timescale 1ns/10ps
module serial_port_status_control_bench;
    logic clk, resetn, psel, penable, pwrite, arm, err, pready, pslverr;
    logic sdi, sck, sck_oe, sdo, sdo_oe, busy;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [7:0] q, prx;
    int miscompares, cmp_count, n, k;
    spsc_pkg::spsc_evt_s evt, e;
    spsc_pkg::spsc_ctl_s ctl;
    spsc_top i_dut (.i_clk(clk), .i_resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .i_evt(evt), .i_sdi(sdi), .o_sck(sck), .o_sck_oe(sck_oe),
        .o_sdo(sdo), .o_sdo_oe(sdo_oe), .o_busy(busy), .o_ctl(ctl));
    spsc_spi_peer i_peer (.i_clk(clk), .i_resetn(resetn), .i_sck(sck), .i_sdo(sdo),
        .i_arm(arm), .i_tx(8'h3c), .o_sdi(sdi), .o_rx(prx));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////
    task final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task chk(input logic [7:0] g, input logic [7:0] x);
        cmp_count++;
        if (g !== x) begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, g, x);
        end
    endtask
    // one apb transfer; waits on pready with a bound, never a fixed latency
    task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (n == 20) begin
            chk(8'h00, 8'h01);
            final_report;
        end
        q = prdata[7:0];
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task ev(input spsc_pkg::spsc_evt_s x);
        @(posedge clk) evt <= x;
        @(posedge clk) evt <= '0;
    endtask
    // polls status until the buffer fills; its own loop variable keeps apb's intact
    task wait_full;
        for (k = 0; k < 300; k++) begin
            apb(0, 12'h000, 8'h00);
            if (q[0] === 1'b1) break;
        end
        chk(q[0], 1'b1);
        if (k == 300) final_report;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        resetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; arm = 1'b0;
        paddr = 12'h000; pwdata = 32'h0; evt = '0; e = '0;
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        apb(0, 12'h000, 8'h00); chk(q, 8'h00);
        apb(0, 12'h004, 8'h00); chk(q, 8'h00);
        apb(0, 12'h010, 8'h00); chk({q[6:0], err}, 8'h01);
        $display("test reset done");
        // spi master /16, clock edge 1, sample phase 0 (peer samples on rising)
        apb(1, 12'h000, 8'h40);
        apb(1, 12'h004, 8'h21);
        @(posedge clk) arm <= 1'b1;
        @(posedge clk) arm <= 1'b0;
        apb(1, 12'h00c, 8'ha5);
        apb(1, 12'h00c, 8'h11);
        wait_full;
        chk(prx, 8'ha5);
        apb(0, 12'h00c, 8'h00); chk(q, 8'h3c);
        apb(0, 12'h000, 8'h00); chk(q[0], 1'b0);
        apb(0, 12'h004, 8'h00); chk(q, 8'ha1);
        // clock /4, end-of-bit sampling: the last bit is taken on the final edge
        apb(1, 12'h000, 8'hc0);
        apb(1, 12'h004, 8'ha0);
        @(posedge clk) arm <= 1'b1;
        @(posedge clk) arm <= 1'b0;
        apb(1, 12'h00c, 8'h5c);
        wait_full;
        chk(prx, 8'h5c);
        apb(0, 12'h00c, 8'h00); chk(q, 8'h3c);
        apb(1, 12'h004, 8'h31); apb(0, 12'h004, 8'h00); chk(q, 8'h31);
        @(posedge clk);
        @(negedge clk) chk({sck, ctl.pins_own}, 2'b11);
        apb(1, 12'h004, 8'h01);
        @(negedge clk) chk({sck_oe, ctl.pins_own}, 2'b00);
        $display("test spi done");
        // spi slave: a byte that meets a full buffer is dropped
        apb(1, 12'h000, 8'h40);
        apb(1, 12'h004, 8'h25);
        e = '0; e.byte_rx = 1'b1; e.rx_data = 8'h96; ev(e);
        e.rx_data = 8'h69; ev(e);
        apb(0, 12'h004, 8'h00); chk(q, 8'h65);
        apb(0, 12'h00c, 8'h00); chk(q, 8'h96);
        $display("test spi slave done");
        // i2c 7-bit then 10-bit slave and i2c master, events from the engine
        apb(1, 12'h004, 8'h26);
        @(negedge clk) chk({ctl.slew_limit, ctl.smbus_levels, ctl.scl_hold}, 3'b111);
        apb(1, 12'h004, 8'h37);
        @(negedge clk) chk(ctl.scl_hold, 1'b0);
        e = '0; e.start_det = 1'b1; ev(e);
        apb(0, 12'h000, 8'h00); chk(q & 8'h3f, 8'h08);
        e = '0; e.addr_match = 1'b1; e.addr_rw = 1'b1; ev(e);
        apb(0, 12'h000, 8'h00); chk(q & 8'h3f, 8'h0c);
        e = '0; e.nack_det = 1'b1; ev(e);
        apb(0, 12'h000, 8'h00); chk(q & 8'h3f, 8'h08);
        e = '0; e.byte_rx = 1'b1; e.byte_is_data = 1'b1; e.rx_data = 8'h5a; ev(e);
        apb(0, 12'h000, 8'h00); chk(q & 8'h3f, 8'h29);
        e.rx_data = 8'hc3; ev(e);
        apb(0, 12'h004, 8'h00); chk(q, 8'h77);
        apb(0, 12'h00c, 8'h00); chk(q, 8'h5a);
        e = '0; e.stop_det = 1'b1; ev(e);
        apb(0, 12'h000, 8'h00); chk(q & 8'h3f, 8'h30);
        e = '0; e.ua_req = 1'b1; ev(e);
        apb(0, 12'h000, 8'h00); chk(q & 8'h3f, 8'h32);
        apb(1, 12'h008, 8'h13);
        apb(0, 12'h000, 8'h00); chk(q & 8'h3f, 8'h30);
        apb(1, 12'h00c, 8'h77);
        apb(0, 12'h000, 8'h00); chk(q[0], 1'b1);
        e = '0; e.tx_done = 1'b1; ev(e);
        apb(0, 12'h000, 8'h00); chk(q[0], 1'b0);
        apb(1, 12'h004, 8'h28);
        @(posedge clk) evt.master_req <= 5'h04;
        @(negedge clk) chk(busy, 1'b1);
        @(posedge clk) evt.master_req <= 5'h00;
        @(negedge clk) chk(busy, 1'b0);
        @(posedge clk) evt.tx_busy <= 1'b1;
        apb(0, 12'h000, 8'h00); chk(q[2], 1'b1);
        apb(1, 12'h00c, 8'h55);
        apb(0, 12'h004, 8'h00); chk(q[7], 1'b1);
        @(posedge clk) evt.tx_busy <= 1'b0;
        apb(1, 12'h004, 8'h06);
        apb(0, 12'h000, 8'h00); chk(q & 8'h18, 8'h00);
        $display("test i2c done");
        final_report;
    end
endmodule

// ### tb/spsc_spi_peer.sv
// spi slave peer model facing the spi master shifter
`timescale 1ns/10ps
module spsc_spi_peer (
    input  wire logic       i_clk,
    input  wire logic       i_resetn,
    input  wire logic       i_sck,
    input  wire logic       i_sdo,
    input  wire logic       i_arm,
    input  wire logic [7:0] i_tx,
    output logic            o_sdi,
    output logic      [7:0] o_rx
);
    logic [7:0] sh_r;
    logic [3:0] cnt_r;
    logic       sck_r;
    logic       sdi_r = 1'b0;
    assign o_sdi = sdi_r;
    always @(posedge i_clk) begin
        sck_r <= i_sck;
        if (!i_resetn) begin
            cnt_r <= 4'h8;
            o_rx  <= 8'h00;
        end else if (i_arm) begin
            sh_r  <= i_tx;
            cnt_r <= 4'h0;
            sdi_r <= i_tx[7];
        end else if (cnt_r == 4'h8) begin
            // line left floating between frames: never a steady level
            sdi_r <= ~sdi_r;
        end else if (i_sck && !sck_r) begin
            o_rx <= {o_rx[6:0], i_sdo};
        end else if (!i_sck && sck_r) begin
            sh_r  <= {sh_r[6:0], 1'b0};
            sdi_r <= sh_r[6];
            cnt_r <= cnt_r + 4'h1;
        end
    end
endmodule

// ### verilog/spsc_defs.svh
// register offsets, field positions, reset values and divider counts
// Operation
// - one serial clock period spans two rollovers of the rate divider
// - SPI master samples input at end of bit when sample phase set, else middle
// - in I2C, sample phase one disables slew limiting, zero enables it
// - SPI clock-edge bit one shifts on active-to-idle, zero on idle-to-active
// - in I2C, clock-edge bit selects SMBus input thresholds
// - I2C data-not-address flag follows the kind of the last byte moved
// - stop-seen flag set by last stop, zero at reset and when disabled
// - start-seen flag set by last start, zero at reset and when disabled
// - I2C slave keeps matched address direction until start, stop or nack
// - I2C master direction flag is transmit busy; or with requests gives busy
// - 10-bit I2C slave sets update-address flag when address must be reloaded
// - buffer-full set when received byte is complete, clear when buffer empty
// - I2C transmit holds buffer-full until the data bits are shifted out
// - buffer write during transmission sets write collision; software clears it
// - SPI slave overflow when byte arrives with unread buffer; new byte lost
// - SPI master never sets the overflow flag
// - I2C overflow when byte arrives with buffer full; software clears it
// - port enable hands serial pins to the port, clear returns them
// - SPI clock polarity one gives idle high, zero idle low
// - I2C slave clock polarity zero stretches the clock, one releases it
// - mode codes 0000, 0001, 0010 give SPI master at clock /4, /16, /64
// - buffer write starts the divider; serial clock is clock/(4*(reload+1))
`ifndef SPSC_DEFS_SVH
`define SPSC_DEFS_SVH
`define SPSC_OFF_STATUS   12'h000
`define SPSC_OFF_CTL1     12'h004
`define SPSC_OFF_RELOAD   12'h008
`define SPSC_OFF_BUFFER   12'h00c
`define SPSC_ST_SMP       7
`define SPSC_ST_CKE       6
`define SPSC_ST_DA        5
`define SPSC_ST_STOP      4
`define SPSC_ST_START     3
`define SPSC_ST_RW        2
`define SPSC_ST_UA        1
`define SPSC_ST_BF        0
`define SPSC_C1_WRITE_COLLISION_FLAG      7
`define SPSC_C1_OV        6
`define SPSC_C1_EN        5
`define SPSC_C1_CKP       4
`define SPSC_C1_MODE_HI   3
`define SPSC_RST_STATUS   8'h00
`define SPSC_RST_CTL1     8'h00
`define SPSC_RST_RELOAD   8'h00
`define SPSC_HALF_DIV4    9'h001
`define SPSC_HALF_DIV16   9'h007
`define SPSC_HALF_DIV64   9'h01f
`define SPSC_LAST_EDGE    4'hf
`endif

// ### verilog/spsc_pkg.sv
// types shared by the serial port status and control block
package spsc_pkg;
    typedef enum logic [3:0] {
        SPSC_SPI_M4   = 4'h0,
        SPSC_SPI_M16  = 4'h1,
        SPSC_SPI_M64  = 4'h2,
        SPSC_SPI_MT2  = 4'h3,
        SPSC_SPI_S_SS = 4'h4,
        SPSC_SPI_S    = 4'h5,
        SPSC_I2C_S7   = 4'h6,
        SPSC_I2C_S10  = 4'h7,
        SPSC_I2C_M    = 4'h8,
        SPSC_SPI_MBRG = 4'ha,
        SPSC_I2C_FW   = 4'hb,
        SPSC_I2C_S7SP = 4'he,
        SPSC_I2C_S10P = 4'hf
    } spsc_mode_e;
    // events from the i2c / spi slave protocol engine (same clock)
    typedef struct packed {
        logic       start_det;
        logic       stop_det;
        logic       nack_det;
        logic       addr_match;
        logic       addr_rw;
        logic       byte_rx;
        logic       byte_is_data;
        logic [7:0] rx_data;
        logic       tx_done;
        logic       tx_busy;
        logic       ua_req;
        logic [4:0] master_req;
    } spsc_evt_s;
    // controls handed to pads and to the protocol engine
    typedef struct packed {
        logic       pins_own;
        logic       slew_limit;
        logic       smbus_levels;
        logic       scl_hold;
        logic       tx_load;
        logic [7:0] tx_data;
        logic [7:0] reload;
    } spsc_ctl_s;
endpackage

// ### verilog/spsc_top.sv
// serial port status / control register bank with spi master shifter
`timescale 1ns/10ps
`include "spsc_defs.svh"
module spsc_top (
    input  wire logic              i_clk,
    input  wire logic              i_resetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire spsc_pkg::spsc_evt_s i_evt,
    input  wire logic              i_sdi,
    output logic                   o_sck,
    output logic                   o_sck_oe,
    output logic                   o_sdo,
    output logic                   o_sdo_oe,
    output logic                   o_busy,
    output spsc_pkg::spsc_ctl_s    o_ctl
);
    ////////////////////////////////////////////////////////////////////////
    function automatic logic is_spi_m(input logic [3:0] m);
        is_spi_m = (m == 4'h0) || (m == 4'h1) || (m == 4'h2) || (m == 4'h3) || (m == 4'ha);
    endfunction
    function automatic logic is_spi_s(input logic [3:0] m);
        is_spi_s = (m == 4'h4) || (m == 4'h5);
    endfunction
    function automatic logic is_i2c(input logic [3:0] m);
        is_i2c = (m == 4'h6) || (m == 4'h7) || (m == 4'h8) || (m == 4'hb) || (m >= 4'he);
    endfunction
    function automatic logic is_i2c_s(input logic [3:0] m);
        is_i2c_s = (m == 4'h6) || (m == 4'h7) || (m >= 4'he);
    endfunction

    logic [7:0] smp_cke_r;
    logic       da_r, stop_r, start_r, rw_r, ua_r, bf_r;
    logic       write_collision_flag_r, ov_r, en_r, ckp_r;
    logic [3:0] mode_r;
    logic [7:0] reload_r, buf_r;
    logic       tx_load_r;
    logic [1:0] sdi_sync_r;
    logic [8:0] div_r;
    logic [3:0] edge_r;
    logic [7:0] tx_sh_r, rx_sh_r;
    logic       sck_r, run_r;

    typedef enum logic [0:0] {XF_IDLE, XF_RUN} xf_state_e;
    xf_state_e  xf_r;

    logic       wr_acc, rd_acc, wr_st, wr_c1, wr_rl, wr_buf, rd_buf;
    logic       input_sample_phase, cke, spi_m, spi_s, i2c, i2c_s;
    logic       xf_done, half_end, samp_now, shift_now, busy_tx, rx_byte;
    logic [8:0] half_cnt;
    logic [7:0] status_v, ctl1_v;
    logic       mapped;
    logic       samp_bit;
    logic [7:0] rx_sh_nxt;

    assign input_sample_phase      = smp_cke_r[`SPSC_ST_SMP];
    assign cke      = smp_cke_r[`SPSC_ST_CKE];
    assign spi_m    = is_spi_m(mode_r);
    assign spi_s    = is_spi_s(mode_r);
    assign i2c      = is_i2c(mode_r);
    assign i2c_s    = is_i2c_s(mode_r);

    ////////////////////////////////////////////////////////////////////////
    // apb slave: zero wait states, read data captured in the setup cycle
    assign mapped   = (paddr == `SPSC_OFF_STATUS) || (paddr == `SPSC_OFF_CTL1) ||
                      (paddr == `SPSC_OFF_RELOAD) || (paddr == `SPSC_OFF_BUFFER);
    assign pready   = 1'b1;
    assign pslverr  = psel & penable & ~mapped;
    assign wr_acc   = psel & penable & pwrite & mapped;
    assign rd_acc   = psel & penable & ~pwrite & mapped;
    assign wr_st    = wr_acc & (paddr == `SPSC_OFF_STATUS);
    assign wr_c1    = wr_acc & (paddr == `SPSC_OFF_CTL1);
    assign wr_rl    = wr_acc & (paddr == `SPSC_OFF_RELOAD);
    assign wr_buf   = wr_acc & (paddr == `SPSC_OFF_BUFFER);
    assign rd_buf   = rd_acc & (paddr == `SPSC_OFF_BUFFER);

    // master mode: direction bit shows transmit busy instead of captured rw
    assign status_v = {input_sample_phase, cke, da_r, stop_r, start_r,
                       (i2c && !i2c_s) ? i_evt.tx_busy : rw_r, ua_r, bf_r};
    assign ctl1_v   = {write_collision_flag_r, ov_r, en_r, ckp_r, mode_r};

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable) begin
            case (paddr)
                `SPSC_OFF_STATUS: prdata <= {24'h00_0000, status_v};
                `SPSC_OFF_CTL1:   prdata <= {24'h00_0000, ctl1_v};
                `SPSC_OFF_RELOAD: prdata <= {24'h00_0000, reload_r};
                `SPSC_OFF_BUFFER: prdata <= {24'h00_0000, buf_r};
                default:          prdata <= 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control registers
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            smp_cke_r <= `SPSC_RST_STATUS;
            en_r      <= 1'b0;
            ckp_r     <= 1'b0;
            mode_r    <= 4'h0;
            reload_r  <= `SPSC_RST_RELOAD;
        end else begin
            if (wr_st) begin
                smp_cke_r <= {pwdata[7:6], 6'h00};
            end
            if (wr_c1) begin
                en_r   <= pwdata[`SPSC_C1_EN];
                ckp_r  <= pwdata[`SPSC_C1_CKP];
                mode_r <= pwdata[`SPSC_C1_MODE_HI:0];
            end
            if (wr_rl) begin
                reload_r <= pwdata[7:0];
            end
        end
    end

    // a buffer write is refused while a transfer is still shifting
    assign busy_tx = run_r | (i2c & i_evt.tx_busy);

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            write_collision_flag_r <= 1'b0;
            ov_r   <= 1'b0;
        end else begin
            // set wins over a software clear in the same cycle
            write_collision_flag_r <= (wr_buf && en_r && busy_tx) ? 1'b1 :
                      (wr_c1 && !pwdata[`SPSC_C1_WRITE_COLLISION_FLAG]) ? 1'b0 : write_collision_flag_r;
            ov_r   <= (rx_byte && bf_r && en_r && (spi_s || i2c)) ? 1'b1 :
                      (wr_c1 && !pwdata[`SPSC_C1_OV]) ? 1'b0 : ov_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // i2c condition and address status
    assign rx_byte = i_evt.byte_rx & (spi_s | i2c);

    always_ff @(posedge i_clk) begin
        if (!i_resetn || !en_r) begin
            start_r <= 1'b0;
            stop_r  <= 1'b0;
        end else if (i2c && i_evt.stop_det) begin
            stop_r  <= 1'b1;
            start_r <= 1'b0;
        end else if (i2c && i_evt.start_det) begin
            start_r <= 1'b1;
            stop_r  <= 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            rw_r <= 1'b0;
        end else if (i2c_s && i_evt.addr_match) begin
            rw_r <= i_evt.addr_rw;
        end else if (i_evt.start_det || i_evt.stop_det || i_evt.nack_det) begin
            rw_r <= 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            da_r <= 1'b0;
        end else if (i2c && (i_evt.byte_rx || i_evt.tx_done)) begin
            da_r <= i_evt.byte_is_data;
        end
    end

    // update-address flag: set by the engine, cleared when software reloads
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            ua_r <= 1'b0;
        end else if (i_evt.ua_req && (mode_r == 4'h7 || mode_r == 4'hf)) begin
            ua_r <= 1'b1;
        end else if (wr_rl) begin
            ua_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // buffer and buffer-full flag
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            buf_r     <= 8'h00;
            bf_r      <= 1'b0;
            tx_load_r <= 1'b0;
        end else begin
            tx_load_r <= wr_buf & en_r & ~busy_tx & i2c;
            if (!en_r) begin
                bf_r <= 1'b0;
            end else if (xf_done) begin
                buf_r <= rx_sh_nxt;
                bf_r  <= 1'b1;
            end else if (rx_byte && !bf_r) begin
                buf_r <= i_evt.rx_data;
                bf_r  <= 1'b1;
            end else if (wr_buf && !busy_tx) begin
                buf_r <= pwdata[7:0];
                bf_r  <= i2c;
            end else if (i2c && i_evt.tx_done) begin
                bf_r  <= 1'b0;
            end else if (rd_buf) begin
                bf_r  <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // spi master rate divider: two rollovers per serial clock period
    always_comb begin
        case (mode_r)
            4'h0:    half_cnt = `SPSC_HALF_DIV4;
            4'h1:    half_cnt = `SPSC_HALF_DIV16;
            4'h2:    half_cnt = `SPSC_HALF_DIV64;
            default: half_cnt = {reload_r, 1'b1};
        endcase
    end

    assign half_end = run_r && (div_r == 9'h000);

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            div_r <= 9'h000;
        end else if (wr_buf && !busy_tx && spi_m && en_r) begin
            div_r <= half_cnt;
        end else if (half_end) begin
            div_r <= half_cnt;
        end else if (run_r) begin
            div_r <= div_r - 9'h001;
        end
    end

    // input pin synchroniser
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            sdi_sync_r <= 2'b00;
        end else begin
            sdi_sync_r <= {sdi_sync_r[0], i_sdi};
        end
    end

    // shift on odd edges but the last for cke=1, even edges past the first for cke=0
    assign shift_now = half_end && (cke ? (edge_r[0] && edge_r != `SPSC_LAST_EDGE)
                                        : (!edge_r[0] && edge_r != 4'h0));
    // middle sample is the non-shift edge, end sample the shift edge plus, for cke=1, the last edge
    assign samp_now  = half_end && (input_sample_phase ? (cke ? edge_r[0]
                                               : (!edge_r[0] && edge_r != 4'h0))
                                        : (cke ? !edge_r[0] : edge_r[0]));
    assign xf_done   = half_end && (edge_r == `SPSC_LAST_EDGE);
    assign run_r     = (xf_r == XF_RUN);
    // end-of-bit sample of the last bit falls on the final edge, so the
    // buffer takes the shifter's next value or it would lose that bit
    assign samp_bit  = samp_now || (xf_done && input_sample_phase && !cke);
    assign rx_sh_nxt = samp_bit ? {rx_sh_r[6:0], sdi_sync_r[1]} : rx_sh_r;

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            xf_r    <= XF_IDLE;
            edge_r  <= 4'h0;
            tx_sh_r <= 8'h00;
            rx_sh_r <= 8'h00;
        end else begin
            case (xf_r)
                XF_IDLE: begin
                    if (wr_buf && spi_m && en_r) begin
                        xf_r    <= XF_RUN;
                        edge_r  <= 4'h0;
                        tx_sh_r <= pwdata[7:0];
                    end
                end
                XF_RUN: begin
                    if (!en_r) begin
                        xf_r <= XF_IDLE;
                    end else if (half_end) begin
                        edge_r <= edge_r + 4'h1;
                        if (shift_now) begin
                            tx_sh_r <= {tx_sh_r[6:0], 1'b0};
                        end
                        rx_sh_r <= rx_sh_nxt;
                        if (xf_done) begin
                            xf_r <= XF_IDLE;
                        end
                    end
                end
                default: xf_r <= XF_IDLE;
            endcase
        end
    end

    // clock leaves idle level on the first edge and returns on the last
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            sck_r <= 1'b0;
        end else if (!run_r) begin
            sck_r <= ckp_r;
        end else if (half_end) begin
            sck_r <= ~sck_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pins and controls
    assign o_sck    = sck_r;
    assign o_sck_oe = en_r & spi_m;
    assign o_sdo    = tx_sh_r[7];
    assign o_sdo_oe = en_r & (spi_m | spi_s);
    assign o_busy   = i2c & ~i2c_s & (i_evt.tx_busy | (|i_evt.master_req));

    // one process drives the whole struct so it has a single driver
    always_comb begin
        o_ctl.pins_own     = en_r;
        o_ctl.slew_limit   = i2c & ~input_sample_phase;
        o_ctl.smbus_levels = i2c & cke;
        o_ctl.scl_hold     = en_r & i2c_s & ~ckp_r;
        o_ctl.tx_load      = tx_load_r;
        o_ctl.tx_data      = buf_r;
        o_ctl.reload       = reload_r;
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    write_collision_flag_set_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (wr_buf && en_r && run_r) |=> write_collision_flag_r)
        else $error("write collision not flagged");
    ov_master_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (spi_m && !$past(ov_r) && !$past(spi_s) && !$past(i2c)) |-> !ov_r)
        else $error("overflow set in spi master");
    ov_set_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (spi_s && en_r && i_evt.byte_rx && bf_r) |=> (ov_r && $stable(buf_r)))
        else $error("overflow not flagged or buffer overwritten");
    start_clr_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (!en_r) |=> (!start_r && !stop_r))
        else $error("start or stop flag kept while disabled");
    stop_set_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (en_r && i2c && i_evt.stop_det) |=> (stop_r && !start_r))
        else $error("stop flag not set");
    xfer_len_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (!run_r ##1 run_r) |-> run_r [*4])
        else $error("transfer ended too early");
    bf_done_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (xf_done && en_r) |=> (bf_r && buf_r == rx_sh_r))
        else $error("received byte not in buffer");
    sck_idle_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (!run_r ##1 !run_r) |-> (o_sck == $past(ckp_r)))
        else $error("idle clock level wrong");
    rw_cap_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (i2c_s && i_evt.addr_match) |=> (rw_r == $past(i_evt.addr_rw)))
        else $error("direction not captured");
    bf_tx_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (en_r && i2c && i_evt.tx_done && !xf_done && !i_evt.byte_rx && !wr_buf)
            |=> !bf_r)
        else $error("buffer full kept after transmit");
    ua_set_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (i_evt.ua_req && (mode_r == 4'h7 || mode_r == 4'hf)) |=> ua_r)
        else $error("update address flag not set");
    ov_i2c_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (i2c && en_r && i_evt.byte_rx && bf_r && !wr_buf) |=> (ov_r && $stable(buf_r)))
        else $error("i2c overflow not flagged or buffer overwritten");
    pins_off_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (!en_r) |-> (!o_sck_oe && !o_sdo_oe && !o_ctl.pins_own && !o_ctl.scl_hold))
        else $error("pins kept while port disabled");
    sck_toggle_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        half_end |=> (o_sck != $past(o_sck)))
        else $error("serial clock missed a half period");
    sdo_hold_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (run_r && !shift_now) |=> $stable(o_sdo))
        else $error("data out moved off its shift edge");
endmodule
